// >>> ext_ctrl_pkg.sv
// package of constants and types for the external output switch control block
package ext_ctrl_pkg;

  // register byte offsets
  localparam logic [7:0] cfg_ofs      = 8'h00; // live configuration (polarity, ext enable)
  localparam logic [7:0] applied_ofs  = 8'h04; // configuration latched at power up
  localparam logic [7:0] status_ofs   = 8'h08; // live state and message codes
  localparam logic [7:0] irq_stat_ofs = 8'h0c; // sticky events, write one to clear
  localparam logic [7:0] irq_mask_ofs = 8'h10; // interrupt mask
  localparam logic [7:0] out_req_ofs  = 8'h14; // front panel output request and delays

  // field positions
  localparam int pol_bit     = 0;  // 0: high = on, 1: low = on
  localparam int ext_en_bit  = 1;  // 1: external output control on
  localparam int onoff_bit   = 0;
  localparam int shdn_bit    = 1;
  localparam int out_on_bit  = 2;
  localparam int msg_lsb     = 4;  // 3-bit message code field
  localparam int out_req_bit = 0;
  localparam int on_dly_lsb  = 8;  // 8-bit delay fields, units of delay ticks
  localparam int off_dly_lsb = 16;

  // reset values
  localparam logic [1:0] cfg_rst     = 2'h0;
  localparam logic [4:0] irq_rst     = 5'h00;
  localparam logic [2:0] msg_none    = 3'h0;
  localparam logic [2:0] msg_high_on = 3'h1; // polarity high=on but input low
  localparam logic [2:0] msg_low_on  = 3'h2; // polarity low=on but input high

  // interrupt event bits
  localparam int ev_out_on   = 0;
  localparam int ev_out_off  = 1;
  localparam int ev_shdn     = 2;
  localparam int ev_msg      = 3;
  localparam int ev_onoff    = 4;
  localparam int ev_num      = 5;

  // timing: switch debounce 1 ms at 250 MHz, delay tick 1 us
  localparam int clk_mhz        = 250;
  localparam int debounce_us    = 1000;
  localparam int debounce_cyc   = debounce_us * clk_mhz;
  localparam int dly_tick_ns    = 1000;
  localparam int dly_tick_cyc   = dly_tick_ns * clk_mhz / 1000;
  localparam int sync_stages    = 2;

  // output sequencer states
  typedef enum logic [1:0] {
    st_off     = 2'b00,
    st_on_wait = 2'b01,
    st_on      = 2'b10,
    st_off_wait= 2'b11
  } out_st_e;

endpackage

// >>> ext_output_ctrl.sv
// external output on/off and shutdown switch control with apb registers
//
// Contract
// - polarity setting 0 means output on for a high input, 1 means on for a low input.
// - with high-active polarity the output is on while the on/off input is open (high).
// - with low-active polarity the output is on while the on/off input is shorted (low).
// - the on/off input is acted on only when the external control setting is 1.
// - polarity and external enable changes take effect only after a power cycle (reset).
// - high-active polarity with the on/off input low shows message code 001; the code shows it only while external control is 1.
// - low-active polarity with the on/off input high shows message code 002; the code shows it only while external control is 1.
// - under external control the output-on and output-off delays are skipped.
// - a low level on the shutdown input forces the output off regardless of other controls.
// - an open input reads high and a closed switch reads low.
//
// Register access: a write lands at the first access edge. Pready, pslverr and
// read data stand for the one cycle after that edge, so every transfer has one
// wait state. Read data is zero outside that cycle, and an unmapped address
// answers with pslverr, drops the write and reads as zero.
//
// Power-up configuration: the live configuration word is kept through sys_rst,
// like settings held in non-volatile storage. It is copied into the applied word
// at the first edge after reset is released. Only the applied word steers the
// switch logic, so a new polarity or enable needs a reset to take effect.
// Limitation: the live word has no defined value until software first writes it,
// so software sets it and then resets before relying on it.
//
// Output sequencer: under external control the filtered switch level is
// followed at once. Under the front panel request the on and off delays count
// in ticks of tick_cnt clocks. A settled shutdown level forces the output off
// in every state and holds it off while it stays low.
//
// Interrupts: every event sets its sticky status bit. Software clears a bit by
// writing a one to it, and a set in the same cycle wins over the clear. The
// interrupt output is high while any unmasked status bit is set.
//
// Switch inputs: both pins pass through a two-stage synchroniser and a level
// filter, so a contact bounce shorter than the filter time never reaches the
// output stage, the message codes or the event bits.
module ext_output_ctrl
  import ext_ctrl_pkg::*;
#(
  parameter int debounce_cnt = debounce_cyc,
  parameter int tick_cnt     = dly_tick_cyc
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // connector pins, already pulled up externally
  input  wire logic        ext_onoff_in,
  input  wire logic        ext_shdn_in,
  // output stage and display
  output logic             out_enable,
  output logic [2:0]       msg_code,
  output logic             irq
);

  typedef struct packed {
    logic [1:0]        cfg;       // live configuration, kept through reset
    logic [1:0]        applied;   // configuration taken at power up
    logic              cfg_taken; // applied holds the post-reset capture
    logic              out_req;
    logic [7:0]        on_dly;
    logic [7:0]        off_dly;
    out_st_e           ost;
    logic [7:0]        dly_cnt;
    logic [31:0]       tick;
    logic              out_on;
    logic [2:0]        msg;
    logic              onoff_d;
    logic              shdn_d;
    logic [ev_num-1:0] irq_stat;
    logic [ev_num-1:0] irq_mask;
    logic [31:0]       rdata;
    logic              ready;
    logic              slverr;
    logic              irq;
  } ctl_s;

  ctl_s st_r, st_nxt;

  logic onoff_lvl;
  logic shdn_lvl;

  // both switch inputs share one filter design
  switch_filter #(.cnt_max(debounce_cnt)) u_onoff_filt (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .pin_in    (ext_onoff_in),
    .level_out (onoff_lvl)
  );

  switch_filter #(.cnt_max(debounce_cnt)) u_shdn_filt (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .pin_in    (ext_shdn_in),
    .level_out (shdn_lvl)
  );

  logic              pol_low;
  logic              ext_en;
  logic              ext_want;
  logic              want_on;
  logic              shdn_act;
  logic [2:0]        msg_now;
  logic [ev_num-1:0] ev;
  logic              wr;
  logic              rd;
  logic              tick_hit;
  logic              acc;
  logic              mapped;

  // applied configuration drives the logic, never the live one
  always_comb begin
    pol_low  = st_r.applied[pol_bit];
    ext_en   = st_r.applied[ext_en_bit];
    ext_want = pol_low ? ~onoff_lvl : onoff_lvl;
    want_on  = ext_en ? ext_want : st_r.out_req;
    shdn_act = ~shdn_lvl;
    if (ext_en && !pol_low && !onoff_lvl) begin
      msg_now = msg_high_on;
    end else if (ext_en && pol_low && onoff_lvl) begin
      msg_now = msg_low_on;
    end else begin
      msg_now = msg_none;
    end
    // only the first access edge is taken, so a request held for pready is not taken twice
    acc      = psel && penable && !st_r.ready;
    wr       = acc && pwrite;
    rd       = acc && !pwrite;
    mapped   = paddr inside {cfg_ofs, applied_ofs, status_ofs, irq_stat_ofs, irq_mask_ofs, out_req_ofs};
    tick_hit = (st_r.tick >= 32'(tick_cnt - 1));
  end

  // next-state logic: sequencer, events and register file
  always_comb begin
    st_nxt       = st_r;
    ev           = '0;
    st_nxt.ready = 1'b0;
    st_nxt.slverr= 1'b0;

    // capture configuration one cycle after reset release, like a power cycle
    if (!st_r.cfg_taken) begin
      st_nxt.applied   = st_r.cfg;
      st_nxt.cfg_taken = 1'b1;
    end

    st_nxt.tick = tick_hit ? 32'h0 : st_r.tick + 32'h1;

    // output sequencer; shutdown overrides every state
    if (shdn_act) begin
      st_nxt.ost     = st_off;
      st_nxt.out_on  = 1'b0;
      st_nxt.dly_cnt = 8'h0;
    end else begin
      case (st_r.ost)
        st_off: begin
          if (want_on) begin
            if (ext_en || st_r.on_dly == 8'h0) begin
              st_nxt.ost    = st_on;
              st_nxt.out_on = 1'b1;
            end else begin
              st_nxt.ost     = st_on_wait;
              st_nxt.dly_cnt = st_r.on_dly;
            end
          end
        end
        st_on_wait: begin
          if (!want_on) begin
            st_nxt.ost = st_off;
          end else if (ext_en || st_r.dly_cnt == 8'h0) begin
            st_nxt.ost    = st_on;
            st_nxt.out_on = 1'b1;
          end else if (tick_hit) begin
            st_nxt.dly_cnt = st_r.dly_cnt - 8'h1;
          end
        end
        st_on: begin
          if (!want_on) begin
            if (ext_en || st_r.off_dly == 8'h0) begin
              st_nxt.ost    = st_off;
              st_nxt.out_on = 1'b0;
            end else begin
              st_nxt.ost     = st_off_wait;
              st_nxt.dly_cnt = st_r.off_dly;
            end
          end
        end
        st_off_wait: begin
          if (want_on) begin
            st_nxt.ost = st_on;
          end else if (ext_en || st_r.dly_cnt == 8'h0) begin
            st_nxt.ost    = st_off;
            st_nxt.out_on = 1'b0;
          end else if (tick_hit) begin
            st_nxt.dly_cnt = st_r.dly_cnt - 8'h1;
          end
        end
        default: begin
          st_nxt.ost    = st_off;
          st_nxt.out_on = 1'b0;
        end
      endcase
    end

    st_nxt.msg     = msg_now;
    st_nxt.onoff_d = onoff_lvl;
    st_nxt.shdn_d  = shdn_lvl;

    // events from state changes
    ev[ev_out_on]  = st_nxt.out_on && !st_r.out_on;
    ev[ev_out_off] = !st_nxt.out_on && st_r.out_on;
    ev[ev_shdn]    = !shdn_lvl && st_r.shdn_d;
    ev[ev_msg]     = (msg_now != msg_none) && (st_r.msg == msg_none);
    ev[ev_onoff]   = onoff_lvl != st_r.onoff_d;

    // apb answer: ready and error stand for the one cycle after the first access edge
    if (acc) begin
      st_nxt.ready  = 1'b1;
      st_nxt.slverr = !mapped;
    end

    // apb write; read-only words and unmapped addresses drop the data
    if (wr) begin
      case (paddr)
        cfg_ofs: begin
          st_nxt.cfg = pwdata[1:0];
        end
        irq_stat_ofs: begin
          st_nxt.irq_stat = st_r.irq_stat & ~pwdata[ev_num-1:0];
        end
        irq_mask_ofs: begin
          st_nxt.irq_mask = pwdata[ev_num-1:0];
        end
        out_req_ofs: begin
          st_nxt.out_req = pwdata[out_req_bit];
          st_nxt.on_dly  = pwdata[on_dly_lsb +: 8];
          st_nxt.off_dly = pwdata[off_dly_lsb +: 8];
        end
        default: begin
          st_nxt.out_req = st_r.out_req;
        end
      endcase
    end
    // set wins over a clear in the same cycle
    st_nxt.irq_stat = st_nxt.irq_stat | ev;

    // read data is loaded together with ready and is zero in every other cycle
    st_nxt.rdata = 32'h0;
    if (rd) begin
      case (paddr)
        cfg_ofs: begin
          st_nxt.rdata[1:0] = st_r.cfg;
        end
        applied_ofs: begin
          st_nxt.rdata[1:0] = st_r.applied;
        end
        status_ofs: begin
          st_nxt.rdata[onoff_bit]        = onoff_lvl;
          st_nxt.rdata[shdn_bit]         = shdn_lvl;
          st_nxt.rdata[out_on_bit]       = st_r.out_on;
          st_nxt.rdata[msg_lsb +: 3]     = st_r.msg;
        end
        irq_stat_ofs: begin
          st_nxt.rdata[ev_num-1:0] = st_r.irq_stat;
        end
        irq_mask_ofs: begin
          st_nxt.rdata[ev_num-1:0] = st_r.irq_mask;
        end
        out_req_ofs: begin
          st_nxt.rdata[out_req_bit]      = st_r.out_req;
          st_nxt.rdata[on_dly_lsb +: 8]  = st_r.on_dly;
          st_nxt.rdata[off_dly_lsb +: 8] = st_r.off_dly;
        end
        default: begin
          st_nxt.rdata = 32'h0;
        end
      endcase
    end

    st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
  end

  // state register; the live configuration is left out of reset so it survives a power cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r.applied   <= cfg_rst;
      st_r.cfg_taken <= 1'b0;
      st_r.out_req   <= 1'b0;
      st_r.on_dly    <= 8'h0;
      st_r.off_dly   <= 8'h0;
      st_r.ost       <= st_off;
      st_r.dly_cnt   <= 8'h0;
      st_r.tick      <= 32'h0;
      st_r.out_on    <= 1'b0;
      st_r.msg       <= msg_none;
      st_r.onoff_d   <= 1'b1; // idle pin level, so no false edge follows reset
      st_r.shdn_d    <= 1'b1;
      st_r.irq_stat  <= irq_rst;
      st_r.irq_mask  <= irq_rst;
      st_r.rdata     <= 32'h0;
      st_r.ready     <= 1'b0;
      st_r.slverr    <= 1'b0;
      st_r.irq       <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign prdata     = st_r.rdata;
  assign pready     = st_r.ready;
  assign pslverr    = st_r.slverr;
  assign out_enable = st_r.out_on;
  assign msg_code   = st_r.msg;
  assign irq        = st_r.irq;

endmodule

// >>> ext_output_ctrl_assertions.sv
// port checker for the external output switch controller
module ext_output_ctrl_checker
  import ext_ctrl_pkg::*;
#(
  parameter int debounce_cnt = debounce_cyc,
  parameter int tick_cnt     = dly_tick_cyc
) (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        ext_onoff_in,
  input wire logic        ext_shdn_in,
  input wire logic        out_enable,
  input wire logic [2:0]  msg_code,
  input wire logic        irq
);
  // sync stages, filter and output register all fit inside this margin
  localparam int settle = debounce_cnt + 8;
  int shdn_lo;
  int on_hi;
  int on_lo;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // saturating run lengths of the shutdown low level and of both on/off levels
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      shdn_lo <= 0;
      on_hi   <= 0;
      on_lo   <= 0;
    end else begin
      shdn_lo <= ext_shdn_in ? 0 : (shdn_lo < settle ? shdn_lo + 1 : shdn_lo);
      on_hi   <= !ext_onoff_in ? 0 : (on_hi < settle ? on_hi + 1 : on_hi);
      on_lo   <= ext_onoff_in ? 0 : (on_lo < settle ? on_lo + 1 : on_lo);
    end
  end

  pready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  pready_timing_a: assert property ((psel && !penable) ##1 (psel && penable) |=> pready)
    else $error("pready not at second access edge");
  pready_access_a: assert property (pready |-> psel && penable && $past(penable))
    else $error("pready outside access phase");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero when idle");
  shdn_force_a: assert property (shdn_lo >= settle |-> !out_enable)
    else $error("output on during shutdown");
  // the filter accepts a low level after two sync stages plus debounce_cnt cycles
  shdn_rise_a: assert property ($rose(out_enable) |-> shdn_lo < debounce_cnt + 3)
    else $error("output rose with shutdown settled");
  msg_one_a: assert property (on_hi >= settle |-> msg_code != msg_high_on)
    else $error("message one with input high");
  msg_two_a: assert property (on_lo >= settle |-> msg_code != msg_low_on)
    else $error("message two with input low");
endmodule

bind ext_output_ctrl ext_output_ctrl_checker #(
  .debounce_cnt(debounce_cnt),
  .tick_cnt    (tick_cnt)
) ext_output_ctrl_checker_i (
  .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ext_onoff_in(ext_onoff_in), .ext_shdn_in(ext_shdn_in), .out_enable(out_enable),
  .msg_code(msg_code), .irq(irq)
);

// >>> ext_switch_model.sv
// switch contacts on the connector, each behind the device pull-up
module ext_switch_model (
  input  wire logic onoff_closed,
  input  wire logic shdn_closed,
  output logic      onoff_pin,
  output logic      shdn_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // each unit has its own isolated relay contact, so no other unit loads the line
  assign onoff_pin = onoff_closed ? 1'b0 : 1'b1;
  assign shdn_pin  = shdn_closed ? 1'b0 : 1'b1;
endmodule

// >>> external_output_switch_control_tb_top.sv
// self-checking bench for the external output switch controller
module external_output_switch_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ext_ctrl_pkg::*;
  localparam int db     = 4;
  localparam int settle = db + 8;
  logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, err, irq;
  logic        onoff_closed, shdn_closed, onoff_pin, shdn_pin, out_enable;
  logic [7:0]  paddr;
  logic [2:0]  msg_code;
  logic [31:0] pwdata, prdata, rd, lfsr, msk;
  int          failures, checks_done, exp_stat;

  ext_output_ctrl #(.debounce_cnt(db), .tick_cnt(2)) ext_output_ctrl_i (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_onoff_in(onoff_pin), .ext_shdn_in(shdn_pin), .out_enable(out_enable),
    .msg_code(msg_code), .irq(irq));
  ext_switch_model ext_switch_model_i (.onoff_closed(onoff_closed), .shdn_closed(shdn_closed),
    .onoff_pin(onoff_pin), .shdn_pin(shdn_pin));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic stop_test();
    if (failures == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // one apb transfer; holds the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic wait_out(input logic v);
    int n;
    n = 0;
    while (out_enable !== v && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, out_enable}, {31'h0, v});
  endtask

  // reset pulse standing in for a power cycle; the live settings are kept
  task automatic pwr_cycle();
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
  endtask

  // clear every sticky event and zero the expected status
  task automatic clr_stat();
    apb(1'b1, irq_stat_ofs, 32'h1f);
    exp_stat = 0;
  endtask

  initial begin
    {sys_rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    {onoff_closed, shdn_closed} = 2'b00;
    lfsr = 32'h166aa; // seed 91818
    failures = 0;
    checks_done = 0;
    exp_stat = 0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    // the live settings survive reset, so give them a value and power cycle
    apb(1'b1, cfg_ofs, 32'h0);
    pwr_cycle();
    rd_chk(cfg_ofs, 32'h0);
    rd_chk(irq_mask_ofs, 32'h0);
    rd_chk(status_ofs, 32'h3);
    apb(1'b1, 8'h18, 32'hffffffff);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 8'h18, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    // new config is held back until a power cycle
    apb(1'b1, cfg_ofs, 32'h3);
    rd_chk(cfg_ofs, 32'h3);
    rd_chk(applied_ofs, 32'h0);
    apb(1'b1, cfg_ofs, 32'h0);
    pwr_cycle();
    rd_chk(applied_ofs, 32'h0);
    rd_chk(status_ofs, 32'h3);
    // switch closed with external control off: seen in status, output untouched
    onoff_closed <= 1'b1;
    repeat (2 * settle) @(posedge clk);
    exp_stat |= 1 << ev_onoff;
    rd_chk(status_ofs, 32'h2);
    chk({31'h0, out_enable}, 32'h0);
    chk({29'h0, msg_code}, 32'h0);
    rd_chk(irq_stat_ofs, exp_stat);
    clr_stat();
    onoff_closed <= 1'b0;
    repeat (2 * settle) @(posedge clk);
    clr_stat();
    // a contact bounce shorter than the filter is dropped
    onoff_closed <= 1'b1;
    repeat (db - 2) @(posedge clk);
    onoff_closed <= 1'b0;
    repeat (2 * settle) @(posedge clk);
    rd_chk(irq_stat_ofs, exp_stat);
    rd_chk(status_ofs, 32'h3);
    // front panel request with a random on delay and random mask
    lfsr = lfsr_next(lfsr);
    msk = {27'h0, lfsr[4:1], 1'b1};
    apb(1'b1, irq_mask_ofs, msk);
    rd_chk(irq_mask_ofs, msk);
    apb(1'b1, out_req_ofs, {8'h0, 8'h1, 6'h0, lfsr[9:8], 8'h1});
    wait_out(1'b1);
    exp_stat |= 1 << ev_out_on;
    rd_chk(irq_stat_ofs, exp_stat);
    chk({31'h0, irq}, 32'h1);
    clr_stat();
    rd_chk(irq_stat_ofs, exp_stat);
    chk({31'h0, irq}, 32'h0);
    // shutdown wins over the front panel request; events masked first
    apb(1'b1, irq_mask_ofs, 32'h1);
    shdn_closed <= 1'b1;
    repeat (2 * settle) @(posedge clk);
    chk({31'h0, out_enable}, 32'h0);
    exp_stat |= (1 << ev_out_off) | (1 << ev_shdn);
    rd_chk(irq_stat_ofs, exp_stat);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, out_req_ofs, 32'h1);
    apb(1'b1, irq_mask_ofs, 32'h4);
    rd_chk(status_ofs, 32'h1);
    chk({31'h0, irq}, 32'h1);
    repeat (settle) @(posedge clk);
    chk({31'h0, out_enable}, 32'h0);
    clr_stat();
    rd_chk(irq_stat_ofs, exp_stat);
    chk({31'h0, irq}, 32'h0);
    // external control, high = on: panel request and long delays are ignored
    shdn_closed <= 1'b0;
    apb(1'b1, cfg_ofs, 32'h2);
    rd_chk(applied_ofs, 32'h0);
    pwr_cycle();
    rd_chk(applied_ofs, 32'h2);
    apb(1'b1, out_req_ofs, 32'h00ffff00);
    wait_out(1'b1);
    onoff_closed <= 1'b1;
    wait_out(1'b0);
    chk({29'h0, msg_code}, {29'h0, msg_high_on});
    onoff_closed <= 1'b0;
    wait_out(1'b1);
    chk({29'h0, msg_code}, {29'h0, msg_none});
    // external control, low = on: an open input means off
    apb(1'b1, cfg_ofs, 32'h3);
    pwr_cycle();
    rd_chk(applied_ofs, 32'h3);
    apb(1'b1, out_req_ofs, 32'h00ffff01);
    chk({31'h0, out_enable}, 32'h0);
    chk({29'h0, msg_code}, {29'h0, msg_low_on});
    onoff_closed <= 1'b1;
    wait_out(1'b1);
    chk({29'h0, msg_code}, {29'h0, msg_none});
    onoff_closed <= 1'b0;
    wait_out(1'b0);
    stop_test();
  end

  // overall guard against a hang
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    stop_test();
  end
endmodule

// >>> switch_filter.sv
// synchroniser and debouncer for one external switch input
module switch_filter
  import ext_ctrl_pkg::*;
#(
  parameter int cnt_max = debounce_cyc
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic pin_in,
  output logic      level_out
);

  typedef struct packed {
    logic        s1;
    logic        s2;
    logic [31:0] cnt;
    logic        lvl;
  } filt_s;

  filt_s st_r, st_nxt;

  // open pin reads high through the pull-up, so reset to high
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = pin_in;
    st_nxt.s2 = st_r.s1;  // first stage feeds only the second
    if (st_r.s2 == st_r.lvl) begin
      st_nxt.cnt = 32'h0;
    end else if (st_r.cnt >= 32'(cnt_max - 1)) begin
      st_nxt.cnt = 32'h0;
      st_nxt.lvl = st_r.s2; // stable long enough, accept new level
    end else begin
      st_nxt.cnt = st_r.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '{s1: 1'b1, s2: 1'b1, cnt: 32'h0, lvl: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_out = st_r.lvl;

endmodule
